// >>> hw/gate0_cfg.svh
// constants for the gate 0 input select block
`ifndef GATE0_CFG_SVH
`define GATE0_CFG_SVH
`define G0_ADDR_W 4
`define G0_DATA_W 8
`define G0_SEL_W 6
`define G0_NUM_SRC 64
`define G0_ADDR_ENABLE 4'h0
`define G0_ADDR_SEL1 4'h1
`define G0_ADDR_SEL2 4'h2
`define G0_ADDR_SEL3 4'h3
`define G0_ADDR_STATUS 4'h4
`define G0_RST_ENABLE 8'h00
`define G0_RST_SEL 6'h00
`define G0_BIT_D1_INV 0
`define G0_BIT_D1_TRUE 1
`define G0_BIT_D2_INV 2
`define G0_BIT_D2_TRUE 3
`define G0_BIT_D3_INV 4
`define G0_BIT_D3_TRUE 5
`endif

// >>> hw/gate0_pkg.sv
// types shared by the gate 0 input select block
package gate0_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic d3_true;
    logic d3_inv;
    logic d2_true;
    logic d2_inv;
    logic d1_true;
    logic d1_inv;
  } g0_terms_t;
endpackage

// >>> hw/source_mux.sv
// one data input selection multiplexer with registered output
`timescale 1ns/10ps
`include "gate0_cfg.svh"
module source_mux #(
  parameter int SEL_W = `G0_SEL_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [(1<<SEL_W)-1:0] src_i,
  input wire logic [SEL_W-1:0] sel_i,
  output logic data_o
);
  logic data_d;
  logic data_q;
  always_comb begin
    data_d = src_i[sel_i];
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_q <= 1'b0;
    end else begin
      data_q <= data_d;
    end
  end
  assign data_o = data_q;
endmodule

// >>> hw/gate0_input_select.sv
// gate 0 input gating of a configurable logic cell, with register port
// Behaviour
// - enable bit 5 set passes true data 3 into gate 0, clear blocks
// - enable bit 4 set passes inverted data 3 into gate 0, clear blocks
// - enable bit 3 set passes true data 2 into gate 0, clear blocks
// - enable bit 2 set passes inverted data 2 into gate 0, clear blocks
// - each data input picks its source with its own six-bit select field
`timescale 1ns/10ps
`include "gate0_cfg.svh"
module gate0_input_select #(
  parameter int SEL_W = `G0_SEL_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire gate0_pkg::reg_req_t req_i,
  output logic [`G0_DATA_W-1:0] rdata_o,
  input wire logic [(1<<SEL_W)-1:0] src_i,
  output gate0_pkg::g0_terms_t terms_o,
  output logic gate0_o
);
  import gate0_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [`G0_DATA_W-1:0] enable_d;
  logic [`G0_DATA_W-1:0] enable_q;
  logic [SEL_W-1:0] sel1_d;
  logic [SEL_W-1:0] sel1_q;
  logic [SEL_W-1:0] sel2_d;
  logic [SEL_W-1:0] sel2_q;
  logic [SEL_W-1:0] sel3_d;
  logic [SEL_W-1:0] sel3_q;
  logic [`G0_DATA_W-1:0] rdata_d;
  logic [`G0_DATA_W-1:0] rdata_q;
  logic [`G0_DATA_W-1:0] status_w;
  logic cell_data_1;
  logic cell_data_2;
  logic cell_data_3;
  g0_terms_t terms_d;
  g0_terms_t terms_q;
  logic gate0_d;
  logic gate0_q;
  logic wr_en_hit;
  logic wr_sel1_hit;
  logic wr_sel2_hit;
  logic wr_sel3_hit;
  logic rd_en_hit;
  logic rd_sel1_hit;
  logic rd_sel2_hit;
  logic rd_sel3_hit;
  logic rd_status_hit;
  logic g0_d3_true_en;
  logic g0_d3_inv_en;
  logic g0_d2_true_en;
  logic g0_d2_inv_en;
  logic g0_d1_true_en;
  logic g0_d1_inv_en;
  // polarity flags for gate_term: pass the data as is or inverted
  localparam logic TRUE_COPY = 1'b0;
  localparam logic INV_COPY = 1'b1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // select fields read with zeros in the unused high bits
  function automatic logic [`G0_DATA_W-1:0] widen(
    input logic [SEL_W-1:0] v
  );
    widen = {{(`G0_DATA_W-SEL_W){1'b0}}, v};
  endfunction

  // only the low select bits are stored; the high bits read back 0
  function automatic logic [SEL_W-1:0] sel_field(
    input logic [`G0_DATA_W-1:0] d
  );
    sel_field = d[SEL_W-1:0];
  endfunction

  // a write strobe aimed at one register
  function automatic logic wr_hit(
    input reg_req_t r,
    input logic [`G0_ADDR_W-1:0] a
  );
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // a read strobe aimed at one register
  function automatic logic rd_hit(
    input reg_req_t r,
    input logic [`G0_ADDR_W-1:0] a
  );
    rd_hit = r.rd && (r.addr == a);
  endfunction

  // one polarity of a data input, passed only while its enable is set
  function automatic logic gate_term(
    input logic en,
    input logic data,
    input logic inv
  );
    gate_term = en & (data ^ inv);
  endfunction

  // ------------------------------------------------------------
  // register strobes
  // ------------------------------------------------------------
  // one strobe per register keeps the address decode in one place
  assign wr_en_hit = wr_hit(req_i, `G0_ADDR_ENABLE);
  assign wr_sel1_hit = wr_hit(req_i, `G0_ADDR_SEL1);
  assign wr_sel2_hit = wr_hit(req_i, `G0_ADDR_SEL2);
  assign wr_sel3_hit = wr_hit(req_i, `G0_ADDR_SEL3);
  assign rd_en_hit = rd_hit(req_i, `G0_ADDR_ENABLE);
  assign rd_sel1_hit = rd_hit(req_i, `G0_ADDR_SEL1);
  assign rd_sel2_hit = rd_hit(req_i, `G0_ADDR_SEL2);
  assign rd_sel3_hit = rd_hit(req_i, `G0_ADDR_SEL3);
  assign rd_status_hit = rd_hit(req_i, `G0_ADDR_STATUS);

  // ------------------------------------------------------------
  // enable register
  // ------------------------------------------------------------
  // bits 7:6 are stored and read back but gate nothing here
  always_comb begin
    enable_d = enable_q;
    if (wr_en_hit) begin
      enable_d = req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_q <= `G0_RST_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ------------------------------------------------------------
  // gate 0 enable bits
  // ------------------------------------------------------------
  // named copies keep the term logic free of bit positions
  assign g0_d3_true_en = enable_q[`G0_BIT_D3_TRUE];
  assign g0_d3_inv_en = enable_q[`G0_BIT_D3_INV];
  assign g0_d2_true_en = enable_q[`G0_BIT_D2_TRUE];
  assign g0_d2_inv_en = enable_q[`G0_BIT_D2_INV];
  assign g0_d1_true_en = enable_q[`G0_BIT_D1_TRUE];
  assign g0_d1_inv_en = enable_q[`G0_BIT_D1_INV];

  // ------------------------------------------------------------
  // data 1 source select
  // ------------------------------------------------------------
  // a new select reaches the mux one edge after the write
  always_comb begin
    sel1_d = sel1_q;
    if (wr_sel1_hit) begin
      sel1_d = sel_field(req_i.wdata);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel1_q <= SEL_W'(`G0_RST_SEL);
    end else begin
      sel1_q <= sel1_d;
    end
  end

  // ------------------------------------------------------------
  // data 2 source select
  // ------------------------------------------------------------
  // each select is its own group, so one write never disturbs another
  always_comb begin
    sel2_d = sel2_q;
    if (wr_sel2_hit) begin
      sel2_d = sel_field(req_i.wdata);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel2_q <= SEL_W'(`G0_RST_SEL);
    end else begin
      sel2_q <= sel2_d;
    end
  end

  // ------------------------------------------------------------
  // data 3 source select
  // ------------------------------------------------------------
  // data 3 feeds both its true and its inverted gate 0 term
  always_comb begin
    sel3_d = sel3_q;
    if (wr_sel3_hit) begin
      sel3_d = sel_field(req_i.wdata);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel3_q <= SEL_W'(`G0_RST_SEL);
    end else begin
      sel3_q <= sel3_d;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // status shows the gated terms and the gate output for debug
  assign status_w = {1'b0, gate0_q, terms_q};

  // an unmapped or idle address reads 0 rather than old data, so
  // software never mistakes a stale word for an answer
  always_comb begin
    rdata_d = '0;
    if (rd_en_hit) begin
      rdata_d = enable_q;
    end else if (rd_sel1_hit) begin
      rdata_d = widen(sel1_q);
    end else if (rd_sel2_hit) begin
      rdata_d = widen(sel2_q);
    end else if (rd_sel3_hit) begin
      rdata_d = widen(sel3_q);
    end else if (rd_status_hit) begin
      rdata_d = status_w;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata_o = rdata_q;

  // ------------------------------------------------------------
  // data selection
  // ------------------------------------------------------------
  source_mux #(.SEL_W(SEL_W)) u_mux1 (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .src_i(src_i),
    .sel_i(sel1_q),
    .data_o(cell_data_1)
  );
  source_mux #(.SEL_W(SEL_W)) u_mux2 (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .src_i(src_i),
    .sel_i(sel2_q),
    .data_o(cell_data_2)
  );
  source_mux #(.SEL_W(SEL_W)) u_mux3 (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .src_i(src_i),
    .sel_i(sel3_q),
    .data_o(cell_data_3)
  );

  // ------------------------------------------------------------
  // gate 0 input gating
  // ------------------------------------------------------------
  // a blocked term contributes 0, so an all-clear gate reads 0;
  // the terms are kept apart so status can show each one
  always_comb begin
    terms_d.d3_true = gate_term(g0_d3_true_en, cell_data_3, TRUE_COPY);
    terms_d.d3_inv = gate_term(g0_d3_inv_en, cell_data_3, INV_COPY);
    terms_d.d2_true = gate_term(g0_d2_true_en, cell_data_2, TRUE_COPY);
    terms_d.d2_inv = gate_term(g0_d2_inv_en, cell_data_2, INV_COPY);
    terms_d.d1_true = gate_term(g0_d1_true_en, cell_data_1, TRUE_COPY);
    terms_d.d1_inv = gate_term(g0_d1_inv_en, cell_data_1, INV_COPY);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      terms_q <= '0;
    end else begin
      terms_q <= terms_d;
    end
  end

  // ------------------------------------------------------------
  // gate 0 output
  // ------------------------------------------------------------
  // the gate is the or of the enabled terms; the polarity stage that
  // follows it in the cell is outside this block
  always_comb begin
    gate0_d = |terms_d;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate0_q <= 1'b0;
    end else begin
      gate0_q <= gate0_d;
    end
  end
  assign terms_o = terms_q;
  assign gate0_o = gate0_q;
endmodule

// >>> testbench/gate0_input_select_checker.sv
// assertions for the gate 0 input select block
`timescale 1ns/10ps
module gate0_input_select_checker #(
  parameter int SEL_W = 6
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire gate0_pkg::reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic [(1<<SEL_W)-1:0] src_i,
  input wire gate0_pkg::g0_terms_t terms_o,
  input wire logic gate0_o
);
  import gate0_pkg::*;
  // shadow of the enable register, seen only through writes
  logic [7:0] en_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) en_q <= 8'h00;
    else if (req_i.wr && req_i.addr == 4'h0) en_q <= req_i.wdata;
  end
  sequence s_rd(a);
    req_i.rd && req_i.addr == a;
  endsequence
  property p_off(int b, logic t);
    !$past(en_q[b]) |-> !t;
  endproperty
  a_d3t_blocked: assert property (p_off(5, terms_o.d3_true))
    else $error("true data 3 term passed while off");
  a_d3i_blocked: assert property (p_off(4, terms_o.d3_inv))
    else $error("inverted data 3 term passed while off");
  a_d2t_blocked: assert property (p_off(3, terms_o.d2_true))
    else $error("true data 2 term passed while off");
  a_d2i_blocked: assert property (p_off(2, terms_o.d2_inv))
    else $error("inverted data 2 term passed while off");
  a_d1t_blocked: assert property (p_off(1, terms_o.d1_true))
    else $error("true data 1 term passed while off");
  a_d1i_blocked: assert property (p_off(0, terms_o.d1_inv))
    else $error("inverted data 1 term passed while off");
  a_gate_or: assert property (gate0_o == |terms_o)
    else $error("gate output differs from its terms");
  a_rdata_idle: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside a read");
  a_enable_readback: assert property (s_rd(4'h0) |=> rdata_o == $past(en_q))
    else $error("enable readback wrong");
endmodule

// >>> testbench/gate0_input_select_tb.sv
// self-checking bench for the gate 0 input select block
`timescale 1ns/10ps
module gate0_input_select_tb;
  import gate0_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  reg_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic [63:0] src_i = 64'h0;
  g0_terms_t terms_o;
  logic gate0_o;
  int failures = 0;
  int n_tests = 0;
  // top select value 6'h3f is the boundary case
  logic [5:0] sel [1:3] = '{6'h05, 6'h2a, 6'h3f};
  logic v;
  logic t;
  logic [7:0] e;
  gate0_input_select i_gate0_input_select (.ref_clk_i, .rst_b_i, .req_i,
    .rdata_o, .src_i, .terms_o, .gate0_o);
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    req_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    req_i.rd <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 8'h00);
    for (int k = 1; k < 4; k++) wr(4'(k), {2'b11, sel[k]});
    for (int k = 1; k < 4; k++) rd(4'(k), {2'b00, sel[k]});
    rd(4'hf, 8'h00);
    // the unselected sources carry the opposite level, so a wrong pick shows
    for (int b = 0; b < 6; b++) for (int i = 0; i < 2; i++) begin
      v = i[0];
      t = ~(v ^ b[0]);
      e = {1'b0, t, t ? 6'(1 << b) : 6'h00};
      @(posedge ref_clk_i);
      src_i <= v ? 64'h1 << sel[b/2+1] : ~(64'h1 << sel[b/2+1]);
      wr(4'h0, 8'h1 << b);
      @(posedge ref_clk_i);
      #1 chk({1'b0, gate0_o, terms_o}, e);
      rd(4'h4, e);
    end
    rd(4'h0, 8'h20);
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule
bind gate0_input_select gate0_input_select_checker #(.SEL_W(SEL_W))
  i_gate0_input_select_checker (.ref_clk_i, .rst_b_i, .req_i, .rdata_o,
  .src_i, .terms_o, .gate0_o);
